// ### bench/tss_link_model.sv
`timescale 1ns/1ps
module tss_link_model (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             slow,
    input  wire logic             hold,
    output logic [7:0]            in_valid,
    input  wire logic [7:0]       in_ready,
    output logic [7:0][31:0]      in_data,
    input  wire logic [9:0]       out_valid,
    output logic [9:0]            out_ready,
    input  wire logic [9:0][31:0] out_data,
    output logic [9:0][31:0]      last_word,
    output logic [9:0][7:0]       got_cnt
);
    logic [7:0][23:0] sent;
    logic             tog;

    // neighbours count words sent and log words received
    always_ff @(posedge sys_clk) begin
        tog <= rst ? 1'b0 : ~tog;
        for (int j = 0; j < 8; j++) begin
            if (rst) sent[j] <= 24'h0;
            else if (in_ready[j]) sent[j] <= sent[j] + 24'h1;
        end
        for (int k = 0; k < 10; k++) begin
            if (rst) got_cnt[k] <= 8'h0;
            else if (out_valid[k] && out_ready[k]) begin
                got_cnt[k] <= got_cnt[k] + 8'h1;
                last_word[k] <= out_data[k];
            end
        end
    end
    // word n of link j carries j in its top byte
    always_comb begin
        for (int j = 0; j < 8; j++) in_data[j] = {8'(j), sent[j]};
    end
    assign in_valid = {8{~rst}};
    // slow sinks accept every other cycle, hold stalls them all
    assign out_ready = (hold || (slow && tog)) ? 10'h0 : 10'h3ff;
endmodule

// ### bench/tss_switch_sva.sv
`timescale 1ns/1ps
module tss_switch_sva #(
    parameter int DATA_W = 32,
    parameter int PC_W   = 10
) (
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   cpu_out_ready,
    input wire logic [3:0]             pri_in_valid,
    input wire logic [3:0]             pri_in_ready,
    input wire logic [3:0]             sec_in_valid,
    input wire logic [3:0]             sec_in_ready,
    input wire logic [4:0]             pri_out_valid,
    input wire logic [4:0]             pri_out_ready,
    input wire logic [4:0][DATA_W-1:0] pri_out_data,
    input wire logic [4:0]             sec_out_valid,
    input wire logic [4:0]             sec_out_ready,
    input wire logic [4:0][DATA_W-1:0] sec_out_data,
    input wire logic [PC_W-1:0]        pc_value
);
    // one clock domain, synchronous reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // a word is only taken when offered
    pri_take_a: assert property ((pri_in_ready & ~pri_in_valid) == 4'h0)
        else $error("primary word taken without valid");
    sec_take_a: assert property ((sec_in_ready & ~sec_in_valid) == 4'h0)
        else $error("secondary word taken without valid");
    // a stalled output stays valid until accepted; the north output also keeps its word
    pri_hold_a: assert property ((pri_out_valid & ~pri_out_ready) != 5'h0 |=>
        (~pri_out_valid & $past(pri_out_valid & ~pri_out_ready)) == 5'h0)
        else $error("primary output dropped while stalled");
    sec_hold_a: assert property ((sec_out_valid & ~sec_out_ready) != 5'h0 |=>
        (~sec_out_valid & $past(sec_out_valid & ~sec_out_ready)) == 5'h0)
        else $error("secondary output dropped while stalled");
    north_data_a: assert property (pri_out_valid[3] && !pri_out_ready[3] |=>
        $stable(pri_out_data[3]))
        else $error("primary north word changed while stalled");
    sec_data_a: assert property (sec_out_valid[3] && !sec_out_ready[3] |=>
        $stable(sec_out_data[3]))
        else $error("secondary north word changed while stalled");
    // state right after reset
    rst_state_a: assert property ($fell(rst) |-> pc_value == '0
        && pri_out_valid == 5'h0 && sec_out_valid == 5'h0)
        else $error("outputs or counter not cleared by reset");
    rst_fifo_a: assert property ($fell(rst) |-> cpu_out_ready)
        else $error("processor buffer not empty after reset");
endmodule

// ### bench/tss_switch_tb.sv
`timescale 1ns/1ps
module tss_switch_tb;
    logic                sys_clk;
    logic                rst;
    logic                imem_wr_en;
    logic [9:0]          imem_wr_addr;
    logic [63:0]         imem_wr_data;
    logic                cpu_out_valid;
    logic                cpu_out_ready;
    logic [31:0]         cpu_out_data;
    logic [9:0]          pc_value;
    logic                slow;
    logic                hold;
    logic [7:0]          lm_in_valid;
    logic [7:0]          lm_in_ready;
    logic [7:0][31:0]    lm_in_data;
    logic [9:0]          lm_out_valid;
    logic [9:0]          lm_out_ready;
    logic [9:0][31:0]    lm_out_data;
    logic [9:0][31:0]    last_word;
    logic [9:0][7:0]     got_cnt;
    logic [63:0]         prog [10];
    int                  miscompares;
    int                  checks_done;
    const logic [31:0]   exp_word [10] = '{32'h9, 32'h02000000, 32'h1, 32'h1, 32'h1,
                                           32'h07000000, 32'h06000000, 32'h05000000, 32'h1,
                                           32'h1};
    const logic [31:0]   exp_cnt [10] = '{2, 1, 2, 2, 2, 1, 1, 1, 2, 1};

    tss_switch dut (.sys_clk(sys_clk), .rst(rst), .imem_wr_en(imem_wr_en),
        .imem_wr_addr(imem_wr_addr), .imem_wr_data(imem_wr_data),
        .cpu_out_valid(cpu_out_valid), .cpu_out_ready(cpu_out_ready),
        .cpu_out_data(cpu_out_data), .pri_in_valid(lm_in_valid[3:0]),
        .pri_in_ready(lm_in_ready[3:0]), .pri_in_data(lm_in_data[3:0]),
        .sec_in_valid(lm_in_valid[7:4]), .sec_in_ready(lm_in_ready[7:4]),
        .sec_in_data(lm_in_data[7:4]), .pri_out_valid(lm_out_valid[4:0]),
        .pri_out_ready(lm_out_ready[4:0]), .pri_out_data(lm_out_data[4:0]),
        .sec_out_valid(lm_out_valid[9:5]), .sec_out_ready(lm_out_ready[9:5]),
        .sec_out_data(lm_out_data[9:5]), .pc_value(pc_value));
    tss_link_model link (.sys_clk(sys_clk), .rst(rst), .slow(slow), .hold(hold),
        .in_valid(lm_in_valid), .in_ready(lm_in_ready), .in_data(lm_in_data),
        .out_valid(lm_out_valid), .out_ready(lm_out_ready), .out_data(lm_out_data),
        .last_word(last_word), .got_cnt(got_cnt));

    always #5 sys_clk = ~sys_clk;

    // instruction word and route field builders
    function automatic logic [63:0] ins(logic [3:0] op, logic [11:0] tgt, logic [1:0] ext,
        logic [2:0] opnd, logic [1:0] wr, logic [1:0] rd, logic [17:0] pr, logic [17:0] sc);
        ins = {1'b0, op, 1'b1, tgt, ext, opnd, wr, rd, 1'b0, pr, sc};
    endfunction
    function automatic logic [17:0] rt(input int k, input logic [2:0] s);
        rt = 18'(s) << (3 * k);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // load the store under reset, then release
    task automatic start(input int n);
        rst = 1'b1;
        for (int i = 0; i < n; i++) begin
            imem_wr_en = 1'b1;
            imem_wr_addr = 10'(i);
            imem_wr_data = prog[i];
            @(negedge sys_clk);
        end
        imem_wr_en = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    task automatic wait_pc(input logic [9:0] v);
        for (int i = 0; i < 300 && pc_value !== v; i++) @(negedge sys_clk);
        if (pc_value !== v) begin
            miscompares++;
            close_out();
        end
    endtask

    // routes, register moves, cross-domain hop and jumps, prompt or slow sinks
    task automatic t_route(input logic s);
        prog[0] = ins(4'h0, 12'h0, 2'h0, 3'h0, 2'h0, 2'h0, rt(0, 5) | rt(1, 4) | rt(2, 3)
            | rt(3, 2) | rt(4, 1), rt(0, 5) | rt(1, 4) | rt(2, 3) | rt(3, 2));
        prog[1] = ins(4'h0, 12'h0, 2'h1, 3'h2, 2'h1, 2'h0, 18'h0, 18'h0);
        prog[2] = ins(4'h0, 12'h0, 2'h1, 3'h3, 2'h2, 2'h1,
            rt(2, 7) | rt(3, 7) | rt(4, 7) | rt(5, 7), rt(4, 7));
        prog[3] = ins(4'h0, 12'h0, 2'h0, 3'h0, 2'h0, 2'h0, 18'h0, rt(3, 6));
        prog[4] = ins(4'h7, 12'h6, 2'h0, 3'h7, 2'h0, 2'h3, 18'h0, 18'h0);
        prog[5] = ins(4'h0, 12'h0, 2'h0, 3'h0, 2'h0, 2'h0, rt(0, 2), 18'h0);
        prog[6] = ins(4'h4, 12'h8, 2'h0, 3'h0, 2'h3, 2'h0, 18'h0, 18'h0);
        prog[7] = ins(4'h5, 12'h9, 2'h0, 3'h0, 2'h0, 2'h0, rt(0, 7), 18'h0);
        prog[8] = ins(4'h0, 12'h0, 2'h3, 3'h7, 2'h0, 2'h3, 18'h0, 18'h0);
        prog[9] = ins(4'h5, 12'h9, 2'h0, 3'h0, 2'h0, 2'h0, 18'h0, 18'h0);
        slow = s;
        start(10);
        repeat (5) @(negedge sys_clk);
        chk(32'(pc_value), 32'h0);
        chk(32'(lm_out_valid), 32'h0);
        cpu_out_valid = 1'b1;
        cpu_out_data = 32'ha5a50000;
        @(negedge sys_clk);
        cpu_out_valid = 1'b0;
        wait_pc(10'h9);
        repeat (10) @(negedge sys_clk);
        for (int k = 0; k < 10; k++) chk(last_word[k], exp_word[k]);
        for (int k = 0; k < 10; k++) chk(32'(got_cnt[k]), exp_cnt[k]);
    endtask

    // fill the processor buffer against a stalled feed, then drain it
    task automatic t_fifo;
        int n;
        n = 0;
        prog[0] = ins(4'h5, 12'h0, 2'h0, 3'h0, 2'h0, 2'h0, rt(4, 1), 18'h0);
        slow = 1'b0;
        hold = 1'b1;
        start(1);
        cpu_out_valid = 1'b1;
        for (int i = 0; i < 20 && cpu_out_ready === 1'b1; i++) begin
            cpu_out_data = 32'hc0de0000 + 32'(i);
            n++;
            @(negedge sys_clk);
        end
        cpu_out_valid = 1'b0;
        chk(32'(n), 32'h9);
        hold = 1'b0;
        for (int i = 0; i < 100 && got_cnt[4] !== 8'h9; i++) @(negedge sys_clk);
        // a drain that never completes ends the run as a failure
        if (got_cnt[4] !== 8'h9) begin
            miscompares++;
            close_out();
        end
        chk(last_word[4], 32'hc0de0008);
        chk(32'(got_cnt[4]), 32'h9);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        imem_wr_en = 1'b0;
        imem_wr_addr = 10'h0;
        imem_wr_data = 64'h0;
        cpu_out_valid = 1'b0;
        cpu_out_data = 32'h0;
        slow = 1'b0;
        hold = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (4) @(negedge sys_clk);
        t_route(1'b0);
        t_route(1'b1);
        t_fifo();
        close_out();
    end
endmodule

// checker watches the switch ports
bind tss_switch tss_switch_sva #(.DATA_W(DATA_W), .PC_W(PC_W)) chk_i (.sys_clk(sys_clk),
    .rst(rst), .cpu_out_ready(cpu_out_ready), .pri_in_valid(pri_in_valid),
    .pri_in_ready(pri_in_ready), .sec_in_valid(sec_in_valid), .sec_in_ready(sec_in_ready),
    .pri_out_valid(pri_out_valid), .pri_out_ready(pri_out_ready),
    .pri_out_data(pri_out_data), .sec_out_valid(sec_out_valid),
    .sec_out_ready(sec_out_ready), .sec_out_data(sec_out_data), .pc_value(pc_value));

// ### verilog/tss_fifo.sv
`timescale 1ns/1ps
module tss_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic   sys_clk,
    input wire logic   rst,
    tss_fifo_if.buf_side fif
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end

    // honest full and empty from wrap-bit pointers
    assign fif.wr_ready = (wr_ptr ^ {1'b1, {AW{1'b0}}}) != rd_ptr;
    assign fif.rd_valid = wr_ptr != rd_ptr;
    assign fif.rd_data  = mem[rd_ptr[AW-1:0]];
    assign push         = fif.wr_valid & fif.wr_ready;
    assign pop          = fif.rd_valid & fif.rd_ready;

    // storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= fif.wr_data;
        end
    end

    // pointers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ### verilog/tss_fifo_if.sv
`timescale 1ns/1ps
interface tss_fifo_if #(parameter int WIDTH = 32);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    // buffer end
    modport buf_side (input wr_valid, input wr_data, output wr_ready,
                      output rd_valid, output rd_data, input rd_ready);
    // user end
    modport user_side (output wr_valid, output wr_data, input wr_ready,
                       input rd_valid, input rd_data, output rd_ready);
endinterface

// ### verilog/tss_pkg.sv
package tss_pkg;
    // widths and depths
    localparam int TSS_DATA_W     = 32;
    localparam int TSS_PC_W       = 10;
    localparam int TSS_INSTR_W    = 64;
    localparam int TSS_FIFO_DEPTH = 8;
    localparam int TSS_NUM_REGS   = 4;
    localparam int TSS_NUM_OUT    = 6;   // west, south, east, north, compute feed, cross out
    localparam int TSS_SEL_W      = 3;

    // instruction field positions
    localparam int TSS_OP_LO      = 59;  // 4-bit operation, bits 62..59
    localparam int TSS_REL_BIT    = 58;  // relative/absolute form bit
    localparam int TSS_IMM_LO     = 46;  // 12-bit jump target, bits 57..46
    localparam int TSS_IMM_W      = 12;
    localparam int TSS_EXT_LO     = 44;  // extended operation group, bits 45..44
    localparam int TSS_OPND_LO    = 41;  // operand port code, bits 43..41
    localparam int TSS_WIDX_LO    = 39;  // register write index, bits 40..39
    localparam int TSS_RIDX_LO    = 37;  // register read index, bits 38..37
    localparam int TSS_PRI_RT_LO  = 18;  // primary route selectors, bits 35..18
    localparam int TSS_SEC_RT_LO  = 0;   // secondary route selectors, bits 17..0

    // reset values
    localparam int TSS_RESET_PC   = 0;

    // crossbar port selector codes
    localparam logic [2:0] TSS_SEL_NONE  = 3'h0;
    localparam logic [2:0] TSS_SEL_CPU   = 3'h1;
    localparam logic [2:0] TSS_SEL_WEST  = 3'h2;
    localparam logic [2:0] TSS_SEL_SOUTH = 3'h3;
    localparam logic [2:0] TSS_SEL_EAST  = 3'h4;
    localparam logic [2:0] TSS_SEL_NORTH = 3'h5;
    localparam logic [2:0] TSS_SEL_XDOM  = 3'h6;
    localparam logic [2:0] TSS_SEL_REG   = 3'h7;

    // extended operation group codes
    localparam logic [1:0] TSS_EXT_NOP  = 2'h0;
    localparam logic [1:0] TSS_EXT_MOVE = 2'h1;
    localparam logic [1:0] TSS_EXT_JR   = 2'h2;
    localparam logic [1:0] TSS_EXT_JALR = 2'h3;

    // operation codes, relative bit excluded
    localparam logic [3:0] TSS_OPC_EXT   = 4'h0;
    localparam logic [3:0] TSS_OPC_JLTZ  = 4'h1;
    localparam logic [3:0] TSS_OPC_JNEZ  = 4'h2;
    localparam logic [3:0] TSS_OPC_JGEZ  = 4'h3;
    localparam logic [3:0] TSS_OPC_JAL   = 4'h4;
    localparam logic [3:0] TSS_OPC_J     = 4'h5;
    localparam logic [3:0] TSS_OPC_JGTZ  = 4'h6;
    localparam logic [3:0] TSS_OPC_JEQZ  = 4'h7;
    localparam logic [3:0] TSS_OPC_JLEZ  = 4'hc;
    localparam logic [3:0] TSS_OPC_JNEZD = 4'hd;
    localparam logic [3:0] TSS_OPC_JEQZD = 4'he;
    localparam logic [3:0] TSS_OPC_DEBUG = 4'hf;
endpackage

// ### verilog/tss_switch.sv
// Overview of operation
// - four-entry register file, one read port, one write port, shared per instruction
// - two crossbars forward words toward neighbouring switches in one cycle
// - sequencer fetches and runs moves, jumps and conditional branches
// - each instruction holds one control operation plus two route lists
// - cross-domain output word appears on other crossbar's input next cycle
// - one read index fanned out plus one register write runs in one step
// - primary selectors: 0 none, 1 processor, W S E N, cross, 7 register
// - extended group: 00 nop, 01 move, 10 jump reg, 11 jump-and-link reg
// - opcode picks branch/jump kind; the bit just below it marks relative form
// - relative branches and absolute jumps are executed identically
`timescale 1ns/1ps
module tss_switch #(
    parameter int DATA_W     = tss_pkg::TSS_DATA_W,
    parameter int PC_W       = tss_pkg::TSS_PC_W,
    parameter int FIFO_DEPTH = tss_pkg::TSS_FIFO_DEPTH
) (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    input  wire logic                                  imem_wr_en,
    input  wire logic [PC_W-1:0]                       imem_wr_addr,
    input  wire logic [tss_pkg::TSS_INSTR_W-1:0]       imem_wr_data,
    input  wire logic                                  cpu_out_valid,
    output logic                                       cpu_out_ready,
    input  wire logic [DATA_W-1:0]                     cpu_out_data,
    input  wire logic [3:0]                            pri_in_valid,
    output logic      [3:0]                            pri_in_ready,
    input  wire logic [3:0][DATA_W-1:0]                pri_in_data,
    input  wire logic [3:0]                            sec_in_valid,
    output logic      [3:0]                            sec_in_ready,
    input  wire logic [3:0][DATA_W-1:0]                sec_in_data,
    output logic      [4:0]                            pri_out_valid,
    input  wire logic [4:0]                            pri_out_ready,
    output logic      [4:0][DATA_W-1:0]                pri_out_data,
    output logic      [4:0]                            sec_out_valid,
    input  wire logic [4:0]                            sec_out_ready,
    output logic      [4:0][DATA_W-1:0]                sec_out_data,
    output logic      [PC_W-1:0]                       pc_value
);
    import tss_pkg::*;

    initial begin
        if (PC_W < 1 || PC_W > TSS_IMM_W || DATA_W < PC_W) begin
            $error("pc width must fit the jump field and the data word");
        end
    end

    logic [TSS_INSTR_W-1:0] imem [2**PC_W];
    logic [TSS_INSTR_W-1:0] instr;
    logic [DATA_W-1:0]      regs [TSS_NUM_REGS];
    logic [DATA_W-1:0]      rd_val;
    logic [PC_W-1:0]        pc;
    logic [PC_W-1:0]        pc_inc;
    logic [PC_W-1:0]        next_pc;
    logic [1:0]             xd_valid;
    logic [1:0][DATA_W-1:0] xd_data;
    logic [1:0][7:0]        src_valid;
    logic [1:0][7:0][DATA_W-1:0] src_data;
    logic [1:0][5:0][2:0]   sel;
    logic [1:0][5:0]        ov;
    logic [1:0][5:0][DATA_W-1:0] od;
    logic [1:0][5:0]        slot_free;
    logic [1:0][7:0]        used;
    logic [3:0]             opc;
    logic [1:0]             ext;
    logic [2:0]             opnd_sel;
    logic [DATA_W-1:0]      opnd;
    logic                   uses_opnd;
    logic                   src_ok;
    logic                   dst_ok;
    logic                   fire;
    logic                   reg_we;
    logic [DATA_W-1:0]      reg_wdata;
    logic                   take;
    logic [PC_W-1:0]        target;

    tss_fifo_if #(.WIDTH(DATA_W)) cpu_if ();

    // processor output words are buffered before the crossbars
    tss_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_cpu_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .fif     (cpu_if.buf_side)
    );
    assign cpu_if.wr_valid = cpu_out_valid;
    assign cpu_if.wr_data  = cpu_out_data;
    assign cpu_out_ready   = cpu_if.wr_ready;

    assign instr    = imem[pc];
    assign opc      = instr[TSS_OP_LO +: 4];
    assign ext      = instr[TSS_EXT_LO +: 2];
    assign opnd_sel = instr[TSS_OPND_LO +: 3];
    assign target   = instr[TSS_IMM_LO +: PC_W];
    assign pc_inc   = pc + 1'b1;
    assign pc_value = pc;
    assign rd_val   = regs[instr[TSS_RIDX_LO +: 2]];

    // source tables per crossbar; each sees only its own links
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            src_valid[c][TSS_SEL_NONE] = 1'b1;
            src_data[c][TSS_SEL_NONE]  = '0;
            src_valid[c][TSS_SEL_CPU]  = cpu_if.rd_valid;
            src_data[c][TSS_SEL_CPU]   = cpu_if.rd_data;
            for (int i = 0; i < 4; i++) begin
                src_valid[c][i+2] = (c == 0) ? pri_in_valid[i] : sec_in_valid[i];
                src_data[c][i+2]  = (c == 0) ? pri_in_data[i] : sec_in_data[i];
            end
            // cross input is the other crossbar's cross output
            src_valid[c][TSS_SEL_XDOM] = xd_valid[1-c];
            src_data[c][TSS_SEL_XDOM]  = xd_data[1-c];
            src_valid[c][TSS_SEL_REG]  = 1'b1;
            src_data[c][TSS_SEL_REG]   = rd_val;
        end
    end

    // route selectors and destination slot state
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < TSS_NUM_OUT; k++) begin
                sel[c][k] = instr[(c == 0 ? TSS_PRI_RT_LO : TSS_SEC_RT_LO) + 3*k +: 3];
                if (k == TSS_NUM_OUT - 1) begin
                    slot_free[c][k] = !xd_valid[c];
                end else begin
                    slot_free[c][k] = !ov[c][k] ||
                                      (c == 0 ? pri_out_ready[k] : sec_out_ready[k]);
                end
            end
        end
    end

    // operand needs: branches test it, move and register jumps take it
    always_comb begin
        unique case (opc)
            TSS_OPC_EXT:                uses_opnd = ext != TSS_EXT_NOP;
            TSS_OPC_J, TSS_OPC_JAL,
            TSS_OPC_DEBUG:              uses_opnd = 1'b0;
            default:                    uses_opnd = 1'b1;
        endcase
    end
    // operand from primary port map, register or port
    assign opnd = src_data[0][opnd_sel];

    always_comb begin
        src_ok = !uses_opnd || src_valid[0][opnd_sel];
        dst_ok = 1'b1;
        used   = '0;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < TSS_NUM_OUT; k++) begin
                src_ok = src_ok & src_valid[c][sel[c][k]];
                dst_ok = dst_ok & ((sel[c][k] == TSS_SEL_NONE) | slot_free[c][k]);
                used[c][sel[c][k]] = 1'b1;
            end
        end
        if (uses_opnd) begin
            used[0][opnd_sel] = 1'b1;
        end
    end
    assign fire = src_ok & dst_ok;

    // inputs consumed only when the instruction fires
    assign cpu_if.rd_ready = fire & (used[0][TSS_SEL_CPU] | used[1][TSS_SEL_CPU]);
    assign pri_in_ready    = fire ? used[0][5:2] : 4'h0;
    assign sec_in_ready    = fire ? used[1][5:2] : 4'h0;

    // crossbar output slots, all routes in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ov <= '0;
            od <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < TSS_NUM_OUT - 1; k++) begin
                    if (fire && sel[c][k] != TSS_SEL_NONE) begin
                        ov[c][k] <= 1'b1;
                        od[c][k] <= src_data[c][sel[c][k]];
                    end else if (c == 0 ? pri_out_ready[k] : sec_out_ready[k]) begin
                        ov[c][k] <= 1'b0;
                    end
                end
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            pri_out_valid[k] = ov[0][k];
            pri_out_data[k]  = od[0][k];
            sec_out_valid[k] = ov[1][k];
            sec_out_data[k]  = od[1][k];
        end
    end

    // cross-domain hold register, readable next cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xd_valid <= '0;
            xd_data  <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (fire && sel[c][TSS_NUM_OUT-1] != TSS_SEL_NONE) begin
                    xd_valid[c] <= 1'b1;
                    xd_data[c]  <= src_data[c][sel[c][TSS_NUM_OUT-1]];
                end else if (fire && used[1-c][TSS_SEL_XDOM]) begin
                    xd_valid[c] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        take      = 1'b0;
        next_pc   = pc_inc;
        reg_we    = 1'b0;
        reg_wdata = DATA_W'(pc_inc);
        unique case (opc)
            TSS_OPC_EXT: begin
                unique case (ext)
                    TSS_EXT_NOP:  reg_we = 1'b0;
                    TSS_EXT_MOVE: begin
                        reg_we    = 1'b1;
                        reg_wdata = opnd;
                    end
                    TSS_EXT_JR:   begin
                        next_pc = opnd[PC_W-1:0];
                    end
                    TSS_EXT_JALR: begin
                        reg_we  = 1'b1;
                        next_pc = opnd[PC_W-1:0];
                    end
                endcase
            end
            TSS_OPC_J:     take = 1'b1;
            TSS_OPC_JAL: begin
                take   = 1'b1;
                reg_we = 1'b1;
            end
            TSS_OPC_JLTZ:  take = opnd[DATA_W-1];
            TSS_OPC_JGEZ:  take = !opnd[DATA_W-1];
            TSS_OPC_JNEZ:  take = opnd != '0;
            TSS_OPC_JEQZ:  take = opnd == '0;
            TSS_OPC_JGTZ:  take = !opnd[DATA_W-1] && opnd != '0;
            TSS_OPC_JLEZ:  take = opnd[DATA_W-1] || opnd == '0;
            TSS_OPC_JNEZD, TSS_OPC_JEQZD: begin
                take      = (opc == TSS_OPC_JNEZD) ? (opnd != '0) : (opnd == '0);
                reg_we    = 1'b1;
                reg_wdata = opnd - 1'b1;
            end
            default:       take = 1'b0;  // debug and unused codes step on
        endcase
        if (take) begin
            next_pc = target;
        end
    end

    // single write port, one write per step
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int r = 0; r < TSS_NUM_REGS; r++) begin
                regs[r] <= '0;
            end
        end else if (fire && reg_we) begin
            regs[instr[TSS_WIDX_LO +: 2]] <= reg_wdata;
        end
    end

    // program counter advances only on a whole step
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc <= PC_W'(TSS_RESET_PC);
        end else if (fire) begin
            pc <= next_pc;
        end
    end

    // instruction store load port
    always_ff @(posedge sys_clk) begin
        if (imem_wr_en) begin
            imem[imem_wr_addr] <= imem_wr_data;
        end
    end
endmodule
